/* hw/opmode_consts.vh */
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_POWER_CONTROL 8'h87
`define IDX_PORT_WAKE_EN 8'h91
`define IDX_SYS_MODE 8'hce
`define IDX_WAKE_CONFIG 8'hf0
`define IDX_MODE_STATUS 8'hf1

// Power control fields
`define BIT_IDLE_REQ 0
`define BIT_STOP_REQ 1
// System mode control field
`define BIT_LOW_CLOCK_KEEP 0
// Wake configuration fields
`define BIT_HOSC_IS_RC 0
`define BIT_ADC_ON_LOW_CLK 1
`define BIT_T0_ON_LOW_CLK 2
`define BIT_WDT_ALWAYS_ON 3

// Reset values
`define RST_PORT_WAKE_EN 8'h00
`define RST_SYS_MODE 1'b0
`define RST_WAKE_CONFIG 4'h0

// Warm-up counts in oscillator clocks
`define WARM_XTAL_HOSC 2048
`define WARM_RC_HOSC 64
`define WARM_LOSC 4

`endif

/* hw/operating_mode_wakeup_ctrl.v */
// What this block does
// - Keep bit chooses low clock in STOP
// - Stop bit write enters STOP mode
// - Hardware clears stop bit on wake
// - Idle bit write enters IDLE mode
// - Hardware clears idle bit on wake
// - STOP halts oscillators except low clock kept by keep or watchdog bit
// - STOP keeps all software register bits; it clears the warm-up counters
// - First port always wakes; second port per enable
// - ADC/timer-zero wake needs low clock and keep
// - IDLE wakes on enabled interrupt with global enable
// - Wake on rising or falling pin edge
// - Crystal wake waits 2048 plus 4 clocks
// - RC wake waits 64 plus 4 clocks
// - Interrupt wake sets flag, then service runs
// - Reset starts in normal mode
// - IDLE keeps peripherals; STOP gates them all
// - Per-pin second port wake enable, reset 0
// - Idle is bit 0, stop bit 1
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "opmode_consts.vh"

module operating_mode_wakeup_ctrl #(
    // Pin and interrupt vector widths
    parameter PORT_W = 8,
    parameter INT_W = 8,
    // Warm-up lengths in oscillator clocks; shorten only for simulation
    // Limitation: counters hold WARM_XTAL up to 4095 and WARM_LOW up to 7
    parameter WARM_XTAL = `WARM_XTAL_HOSC,
    parameter WARM_RC = `WARM_RC_HOSC,
    parameter WARM_LOW = `WARM_LOSC
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Wake pins
    input wire [PORT_W-1:0] first_port,
    input wire [PORT_W-1:0] second_port,
    // Interrupt side
    input wire global_interrupt_enable,
    input wire [INT_W-1:0] int_request,
    input wire [INT_W-1:0] int_enable,
    input wire adc_irq,
    input wire timer_zero_irq,
    // Oscillator ticks, one pulse per oscillator clock
    input wire hosc_tick,
    input wire losc_tick,
    // Clock and mode controls
    output reg cpu_clk_en,
    output reg periph_clk_en,
    output reg hosc_run,
    output reg losc_run,
    output reg int_logic_en,
    output reg [1:0] wake_flag_set,
    output reg [2:0] mode_state
);

    // Mode states
    // Warm-up is split so the high and low counts stay separate
    // Codes are visible on mode_state and in the status register
    // Running: every clock on
    localparam ST_NORMAL = 3'd0;
    // Processor clock gated, peripherals run
    localparam ST_IDLE = 3'd1;
    // Everything halted but the low clock kept by keep or watchdog bit
    localparam ST_STOP = 3'd2;
    // Oscillators settling after a STOP wake
    // Warm states count as STOP for peripheral gating
    localparam ST_WARM_H = 3'd3;
    localparam ST_WARM_L = 3'd4;

    // Register state; STOP leaves the software bits alone but clears the warm-up counters
    // Power control request bits
    reg idle_req_reg;
    reg stop_req_reg;
    // Low clock keep bit
    reg keep_reg;
    // Per-pin enables for the second port
    reg [PORT_W-1:0] wake_en_reg;
    // Oscillator type and low-clock wake sources
    reg [3:0] cfg_reg;
    // Mode state and its next value
    reg [2:0] state_reg;
    reg [2:0] state_next;
    // Warm-up progress, cleared while in STOP
    reg [11:0] hcnt_reg;
    reg [2:0] lcnt_reg;
    // Cause of the last STOP wake as {adc, timer zero}
    reg [1:0] cause_reg;

    // Pin synchronisers and previous levels
    // Reset to zero, so a pin high at release reads as a later edge
    reg [PORT_W-1:0] p0_s1_reg;
    reg [PORT_W-1:0] p0_s2_reg;
    reg [PORT_W-1:0] p0_old_reg;
    // Second port, same structure
    reg [PORT_W-1:0] p1_s1_reg;
    reg [PORT_W-1:0] p1_s2_reg;
    reg [PORT_W-1:0] p1_old_reg;

    // Decoded bus strobes
    // Setup phase: read data is latched here, one cycle ahead of access
    wire setup_ph = psel & ~penable;
    // Write lands only on the access edge that also sees pready
    wire wr_stb = psel & penable & pready & pwrite;
    // Word index; the two low address bits are ignored
    // Limitation: misaligned byte addresses alias onto the same word
    wire [9:0] idx = paddr[11:2];

    // Index match helper, used by read and write decoding
    // Upper index bits must be zero, so no register aliases higher up
    function hit;
        input [9:0] a;
        input [7:0] r;
        begin
            hit = (a == {2'b00, r});
        end
    endfunction

    // Write strobes; the status register ignores writes
    wire wr_power_control_register = wr_stb & hit(idx, `IDX_POWER_CONTROL);
    wire wr_wake = wr_stb & hit(idx, `IDX_PORT_WAKE_EN);
    wire wr_mode = wr_stb & hit(idx, `IDX_SYS_MODE);
    wire wr_cfg = wr_stb & hit(idx, `IDX_WAKE_CONFIG);

    // Edge on any enabled pin, either direction
    // Synchronised level against its copy one cycle older
    // First port has no enable; second port is masked per pin
    wire [PORT_W-1:0] p0_chg = p0_s2_reg ^ p0_old_reg;
    wire [PORT_W-1:0] p1_chg = (p1_s2_reg ^ p1_old_reg) & wake_en_reg;
    wire pin_wake = (|p0_chg) | (|p1_chg);

    // Low-clock interrupt wake, only while low clock survives STOP
    // Other interrupt logic is halted in STOP and cannot wake it
    // The irq inputs are levels from blocks on the low clock
    wire adc_wake = adc_irq & cfg_reg[`BIT_ADC_ON_LOW_CLK] & keep_reg;
    wire t0_wake = timer_zero_irq & cfg_reg[`BIT_T0_ON_LOW_CLK] & keep_reg;
    wire stop_wake = pin_wake | adc_wake | t0_wake;

    // Any enabled interrupt under the global enable
    // Pin changes wake IDLE just as they wake STOP
    wire idle_wake = pin_wake |
        (global_interrupt_enable & (|(int_request & int_enable)));

    // Warm-up length picked by oscillator type
    // Hazard: changing the type bit during warm-up moves the end point
    wire [11:0] hosc_target = cfg_reg[`BIT_HOSC_IS_RC] ?
        WARM_RC[11:0] : WARM_XTAL[11:0];

    // Done on the tick that completes the count, not the one after
    wire warm_h_done = hosc_tick & (hcnt_reg == hosc_target - 12'd1);
    // Low count ends by the same rule
    wire warm_l_done = losc_tick & (lcnt_reg == WARM_LOW[2:0] - 3'd1);

    // Two-flop synchronisers; first stage feeds only the second
    // Trade-off: two cycles of wake latency buy metastability margin
    // Pins are taken as sampled by clk, which this model never stops
    // Old copies give the level one cycle earlier
    always @(posedge clk) begin
        if (reset) begin
            p0_s1_reg <= {PORT_W{1'b0}};
            p0_s2_reg <= {PORT_W{1'b0}};
            p1_s1_reg <= {PORT_W{1'b0}};
            p1_s2_reg <= {PORT_W{1'b0}};
            p0_old_reg <= {PORT_W{1'b0}};
            p1_old_reg <= {PORT_W{1'b0}};
        end else begin
            p0_s1_reg <= first_port;
            p0_s2_reg <= p0_s1_reg;
            p1_s1_reg <= second_port;
            p1_s2_reg <= p1_s1_reg;
            p0_old_reg <= p0_s2_reg;
            p1_old_reg <= p1_s2_reg;
        end
    end

    // Mode sequencing
    // Power writes outside NORMAL only store bits, no transition
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL: begin
                // Stop wins if both bits are written together
                if (wr_power_control_register && pwdata[`BIT_STOP_REQ])
                    state_next = ST_STOP;
                else if (wr_power_control_register && pwdata[`BIT_IDLE_REQ])
                    state_next = ST_IDLE;
            end
            ST_IDLE: begin
                // High clock never stopped, so no warm-up
                if (idle_wake)
                    state_next = ST_NORMAL;
            end
            ST_STOP: begin
                // Enabled pin edge or a kept low-clock interrupt
                if (stop_wake)
                    state_next = ST_WARM_H;
            end
            ST_WARM_H: begin
                // High oscillator settles first
                if (warm_h_done)
                    state_next = ST_WARM_L;
            end
            ST_WARM_L: begin
                // Then a few low oscillator ticks
                if (warm_l_done)
                    state_next = ST_NORMAL;
            end
            default: begin
                // Unused codes fall back to NORMAL
                state_next = ST_NORMAL;
            end
        endcase
    end

    // State, warm-up counters and wake cause
    // Only one counter moves at a time, so no priority clash
    // cause_reg outlives the wake so the status register can show it
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_NORMAL;
            hcnt_reg <= 12'h000;
            lcnt_reg <= 3'h0;
            cause_reg <= 2'b00;
        end else begin
            state_reg <= state_next;
            // Counters cleared on STOP entry so each wake counts fresh
            if (state_reg == ST_STOP) begin
                hcnt_reg <= 12'h000;
                lcnt_reg <= 3'h0;
                if (stop_wake)
                    cause_reg <= {adc_wake, t0_wake};
            end else if (state_reg == ST_WARM_H && hosc_tick) begin
                hcnt_reg <= hcnt_reg + 12'd1;
            end else if (state_reg == ST_WARM_L && losc_tick) begin
                lcnt_reg <= lcnt_reg + 3'd1;
            end
        end
    end

    // Software registers; hardware clear on wake
    // Writes land in any mode; only NORMAL acts on the request bits
    // Reserved bits are dropped on write and read back as zero
    // Idle bit clears on IDLE wake, stop bit when warm-up ends; a bit stored without its own transition stays set
    always @(posedge clk) begin
        if (reset) begin
            idle_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
            keep_reg <= `RST_SYS_MODE;
            wake_en_reg <= `RST_PORT_WAKE_EN;
            cfg_reg <= `RST_WAKE_CONFIG;
        end else begin
            // A fresh software set wins over the wake-time clear
            if (wr_power_control_register)
                idle_req_reg <= pwdata[`BIT_IDLE_REQ];
            else if (state_reg == ST_IDLE && idle_wake)
                idle_req_reg <= 1'b0;
            if (wr_power_control_register)
                stop_req_reg <= pwdata[`BIT_STOP_REQ];
            else if (state_reg == ST_WARM_L && warm_l_done)
                stop_req_reg <= 1'b0;
            // Keep bit is sampled live, so it must be set before STOP
            if (wr_mode)
                keep_reg <= pwdata[`BIT_LOW_CLOCK_KEEP];
            if (wr_wake)
                wake_en_reg <= pwdata[PORT_W-1:0];
            if (wr_cfg)
                cfg_reg <= pwdata[3:0];
        end
    end

    // Clock gating and wake flag outputs
    // All enables come from state_next, so they move with mode_state
    // The high oscillator runs through warm-up; its ticks are counted
    // Limitation: the flag pulse lasts one cycle; the sink must latch it
    always @(posedge clk) begin
        if (reset) begin
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            hosc_run <= 1'b1;
            losc_run <= 1'b1;
            int_logic_en <= 1'b1;
            wake_flag_set <= 2'b00;
            mode_state <= ST_NORMAL;
        end else begin
            mode_state <= state_next;
            cpu_clk_en <= (state_next == ST_NORMAL);
            // Peripherals stay up in IDLE, down through STOP and warm-up
            periph_clk_en <= (state_next == ST_NORMAL) ||
                (state_next == ST_IDLE);
            int_logic_en <= (state_next == ST_NORMAL) ||
                (state_next == ST_IDLE);
            hosc_run <= (state_next != ST_STOP);
            // Watchdog always-on also keeps the low clock in STOP
            losc_run <= (state_next != ST_STOP) || keep_reg ||
                cfg_reg[`BIT_WDT_ALWAYS_ON];
            // Request flags raised as warm-up ends, so service follows
            if (state_reg == ST_WARM_L && warm_l_done)
                wake_flag_set <= cause_reg;
            else
                wake_flag_set <= 2'b00;
        end
    end

    // APB answer, registered in setup so access sees it at once
    // Zero wait states: pready rises in the first access cycle
    // prdata reads zero outside the access cycle
    // Unmapped index: pslverr with pready, write ignored
    always @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (setup_ph) begin
                if (hit(idx, `IDX_POWER_CONTROL))
                    prdata <= {30'h0, stop_req_reg, idle_req_reg};
                else if (hit(idx, `IDX_PORT_WAKE_EN))
                    prdata <= {{(32-PORT_W){1'b0}}, wake_en_reg};
                else if (hit(idx, `IDX_SYS_MODE))
                    prdata <= {31'h0, keep_reg};
                else if (hit(idx, `IDX_WAKE_CONFIG))
                    prdata <= {28'h0, cfg_reg};
                // Status is read-only
                else if (hit(idx, `IDX_MODE_STATUS))
                    prdata <= {27'h0, cause_reg, state_reg};
                else
                    pslverr <= 1'b1; // Unmapped: error, reads zero
            end
        end
    end

endmodule // operating_mode_wakeup_ctrl

/* test/opmode_checker.sv */
`timescale 1ns/1ps
module opmode_checker #(
    parameter WARM_XTAL = 2048,
    parameter WARM_RC = 64,
    parameter WARM_LOW = 4
) (
    // Clock, reset and bus
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    // Wake causes and ticks
    input wire global_interrupt_enable,
    input wire [7:0] int_request,
    input wire [7:0] int_enable,
    input wire hosc_tick,
    input wire losc_tick,
    // Mode outputs
    input wire cpu_clk_en,
    input wire periph_clk_en,
    input wire hosc_run,
    input wire int_logic_en,
    input wire [1:0] wake_flag_set,
    input wire [2:0] mode_state
);
    // Ticks seen in each warm-up phase
    int hcnt;
    int lcnt;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Counters clear outside their phase
    always @(posedge clk) begin
        hcnt <= (mode_state == 3'h3) ? hcnt + int'(hosc_tick) : 0;
        lcnt <= (mode_state == 3'h4) ? lcnt + int'(losc_tick) : 0;
    end
    sequence wr_pwr;
        psel && penable && pready && pwrite && paddr == 12'h21c && mode_state == 3'h0;
    endsequence
    sequence hi_done;
        mode_state == 3'h3 ##1 mode_state == 3'h4;
    endsequence
    sequence lo_done;
        mode_state == 3'h4 ##1 mode_state == 3'h0;
    endsequence
    AST_STOP_ENTRY: assert property (wr_pwr ##0 pwdata[1] |=> mode_state == 3'h2)
        else $error("stop not entered");
    AST_IDLE_ENTRY: assert property (wr_pwr ##0 pwdata[1:0] == 2'h1 |=> mode_state == 3'h1)
        else $error("idle not entered");
    AST_CPU_GATE: assert property (cpu_clk_en == (mode_state == 3'h0))
        else $error("cpu clock wrong");
    AST_STOP_QUIET: assert property (mode_state == 3'h2 |->
        !hosc_run && !periph_clk_en && !int_logic_en)
        else $error("stop left clocks on");
    AST_IDLE_RUN: assert property (mode_state == 3'h1 |->
        hosc_run && periph_clk_en && int_logic_en)
        else $error("idle stopped clocks");
    AST_IDLE_WAKE: assert property (mode_state == 3'h1 && global_interrupt_enable
        && |(int_request & int_enable) |=> mode_state == 3'h0)
        else $error("idle did not wake");
    AST_WARM_HIGH: assert property (hi_done |-> hcnt == WARM_XTAL || hcnt == WARM_RC)
        else $error("high warm count wrong");
    AST_WARM_LOW: assert property (lo_done |-> lcnt == WARM_LOW)
        else $error("low warm count wrong");
    AST_FLAG_PULSE: assert property (|wake_flag_set |-> $past(mode_state) == 3'h4 ##1 !wake_flag_set)
        else $error("wake flag pulse wrong");
    AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready timing wrong");
endmodule // opmode_checker
bind operating_mode_wakeup_ctrl opmode_checker #(.WARM_XTAL(WARM_XTAL), .WARM_RC(WARM_RC),
    .WARM_LOW(WARM_LOW)) chk_i (.*);

/* test/wake_source_model.sv */
`timescale 1ns/1ps
module wake_source_model (
    // Clock and pace
    input wire clk,
    input wire slow,
    // Oscillator enables from the block; a halted oscillator gives no ticks
    input wire hosc_run,
    input wire losc_run,
    // Oscillator ticks, one cycle each
    output logic hosc_tick = 1'b0,
    output logic losc_tick = 1'b0
);
    // Free divider; slow pace stretches the high clock
    logic [3:0] div = 4'h0;
    always @(posedge clk) begin
        div <= div + 4'h1;
        hosc_tick <= hosc_run && (slow ? (div[1:0] == 2'h0) : 1'b1);
        losc_tick <= losc_run && (div == 4'h7);
    end
endmodule // wake_source_model

/* test/operating_mode_wakeup_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "opmode_consts.vh"
module operating_mode_wakeup_ctrl_tb_top;
    // Driven inputs
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic gie = 1'b0, adc_irq = 1'b0, t0_irq = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [7:0] p0 = 8'h00, p1 = 8'h00, ireq = 8'h00, ien = 8'h00;
    // Observed outputs
    wire [31:0] prdata;
    wire [2:0] mode;
    wire [1:0] flag;
    wire pready, pslverr, htick, ltick, cpu_en, per_en, hrun, lrun, int_en;
    logic rerr;
    int fail_count = 0, checks = 0, n;
    always #50 clk = ~clk;
    operating_mode_wakeup_ctrl #(.WARM_XTAL(8), .WARM_RC(4), .WARM_LOW(4)) uut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_port(p0), .second_port(p1), .global_interrupt_enable(gie),
        .int_request(ireq), .int_enable(ien), .adc_irq(adc_irq), .timer_zero_irq(t0_irq),
        .hosc_tick(htick), .losc_tick(ltick), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
        .hosc_run(hrun), .losc_run(lrun), .int_logic_en(int_en), .wake_flag_set(flag),
        .mode_state(mode));
    wake_source_model osc (.clk(clk), .slow(slow), .hosc_run(hrun), .losc_run(lrun),
        .hosc_tick(htick), .losc_tick(ltick));
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds until pready is sampled
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ends on pready; only the watchdog stops this wait if pready never comes
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait for a mode
    task wait_mode(input logic [2:0] m);
        n = 0;
        while (mode !== m && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(32'(mode), 32'(m));
    endtask
    task t_regs;
        chk(32'(mode), 0);
        apb(0, `IDX_PORT_WAKE_EN, 0);
        chk(rdat, 0);
        apb(1, `IDX_PORT_WAKE_EN, 32'h5a);
        apb(0, `IDX_PORT_WAKE_EN, 0);
        chk(rdat, 32'h5a);
        apb(0, 10'h001, 0);
        chk(32'(rerr), 1);
        $display("t_regs done");
    endtask
    task t_idle;
        ien <= 8'h04;
        apb(1, `IDX_POWER_CONTROL, 32'h1);
        @(posedge clk);
        chk({cpu_en, per_en, mode}, 5'h09);
        ireq <= 8'h04;
        repeat (4) @(posedge clk);
        chk(32'(mode), 1);
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(mode), 0);
        ireq <= 8'h00;
        gie <= 1'b0;
        apb(0, `IDX_POWER_CONTROL, 0);
        chk(rdat, 0);
        $display("t_idle done");
    endtask
    task t_stop_pin;
        apb(1, `IDX_SYS_MODE, 1);
        apb(1, `IDX_POWER_CONTROL, 32'h2);
        @(posedge clk);
        chk({mode, hrun, lrun}, 5'h09);
        p1 <= 8'h01;
        repeat (8) @(posedge clk);
        chk(32'(mode), 2);
        p1 <= 8'h03;
        wait_mode(3'h3);
        wait_mode(3'h0);
        apb(0, `IDX_POWER_CONTROL, 0);
        chk(rdat, 0);
        apb(0, `IDX_PORT_WAKE_EN, 0);
        chk(rdat, 32'h5a);
        $display("t_stop_pin done");
    endtask
    task t_stop_timer;
        slow <= 1'b1;
        apb(1, `IDX_WAKE_CONFIG, 32'h5);
        apb(1, `IDX_SYS_MODE, 0);
        apb(1, `IDX_POWER_CONTROL, 32'h2);
        t0_irq <= 1'b1;
        @(posedge clk);
        chk(32'(lrun), 0);
        repeat (8) @(posedge clk);
        chk(32'(mode), 2);
        t0_irq <= 1'b0;
        p0 <= 8'h80;
        wait_mode(3'h0);
        chk(32'(flag), 0);
        apb(1, `IDX_SYS_MODE, 1);
        apb(1, `IDX_POWER_CONTROL, 32'h2);
        t0_irq <= 1'b1;
        wait_mode(3'h3);
        wait_mode(3'h0);
        chk(32'(flag), 1);
        t0_irq <= 1'b0;
        $display("t_stop_timer done");
    endtask
    // ADC wake, watchdog low clock, falling pin edge, status read
    task t_stop_adc;
        apb(1, `IDX_WAKE_CONFIG, 32'ha);
        apb(1, `IDX_SYS_MODE, 0);
        apb(1, `IDX_POWER_CONTROL, 32'h2);
        adc_irq <= 1'b1;
        @(posedge clk);
        chk({mode, hrun, lrun}, 5'h09);
        repeat (8) @(posedge clk);
        chk(32'(mode), 2);
        adc_irq <= 1'b0;
        p0 <= 8'h00;
        wait_mode(3'h3);
        wait_mode(3'h0);
        chk(32'(flag), 0);
        apb(1, `IDX_SYS_MODE, 1);
        apb(1, `IDX_POWER_CONTROL, 32'h2);
        adc_irq <= 1'b1;
        wait_mode(3'h3);
        wait_mode(3'h0);
        chk(32'(flag), 2);
        adc_irq <= 1'b0;
        apb(0, `IDX_MODE_STATUS, 0);
        chk(rdat, 32'h10);
        $display("t_stop_adc done");
    endtask
    task summarize;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial begin
        #2000000;
        fail_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_idle();
        t_stop_pin();
        t_stop_timer();
        t_stop_adc();
        summarize();
    end
endmodule // operating_mode_wakeup_ctrl_tb_top
